//--- design/cpp_defines.svh
// Purpose: Constants of the cyclic profile command parser
// Assumes: 8-bit ASCII frames, four motors A to D
// Notes:   Included by cpp_reply_tx and cpp_parser; definitions only
//
// Function
// - Trigger commands launch on next trigger rising edge
// - After first launch, repeat without further triggers
// - Completed cyclic profile restarts until stop request
// - Position variant references current wanted position
// - Position variant overwrites curve position offset
// - Immediate command starts curve, replies hash ack CR
// - Stopped profiles finish current run, never restart
// - Stop mask bit n selects motor A+n
// - Stop frame drive letter only selects controller
// - Resolution query by id, replies 32-bit microamperes
// - Resolution reply belongs to queried controller id
// - Feed-forward gain 16-bit, 0 to 32640 accepted
`ifndef CPP_DEFINES_SVH
`define CPP_DEFINES_SVH

`define CPP_MOTORS      4
`define CPP_CH_START    8'h21
`define CPP_CH_HASH     8'h23
`define CPP_CH_CR       8'h0d
`define CPP_CH_ZERO     8'h30
`define CPP_CH_NINE     8'h39
`define CPP_CH_A        8'h41
`define CPP_CH_B        8'h42
`define CPP_CH_C        8'h43
`define CPP_CH_D        8'h44
`define CPP_CH_I        8'h49
`define CPP_CH_S        8'h53
`define CPP_CH_T        8'h54
`define CPP_CURVE_MAX   32'h0000_ffff
`define CPP_MASK_MAX    32'h0000_000f
`define CPP_GAIN_MAX    32'h0000_7f80
`define CPP_ACK_OK      32'h0000_0000
`define CPP_ACK_ERR     32'h0000_0001
`define CPP_DEC_BASE    36'h0_0000_000a
`define CPP_NUM_LIMIT   36'h0_ffff_ffff
`define CPP_DIGITS      10

`endif

//--- design/cpp_pkg.sv
// Purpose: Types of the cyclic profile command parser
// Assumes: One-hot state codes
// Notes:   No constants here; see cpp_defines.svh
package cpp_pkg;

    typedef enum logic [5:0] {
        P_IDLE = 6'h01,
        P_CMD1 = 6'h02,
        P_CMD2 = 6'h04,
        P_ARGS = 6'h08,
        P_EXEC = 6'h10,
        P_WAIT = 6'h20
    } cpp_pstate_type;

    typedef enum logic [6:0] {
        CMD_NONE       = 7'h01,
        CMD_START_IMM  = 7'h02,
        CMD_TRIG_START = 7'h04,
        CMD_TRIG_POS   = 7'h08,
        CMD_CS         = 7'h10,
        CMD_RES_QUERY  = 7'h20,
        CMD_FF_GAIN    = 7'h40
    } cpp_cmd_type;

    typedef enum logic [4:0] {
        T_IDLE = 5'h01,
        T_CONV = 5'h02,
        T_HASH = 5'h04,
        T_DIG  = 5'h08,
        T_TERM = 5'h10
    } cpp_tstate_type;

endpackage

//--- design/cpp_reply_tx.sv
// Purpose: Builds a reply frame: hash, decimal value, carriage return
// Assumes: Sink takes a byte when tx_valid and tx_ready are both high
// Notes:   One digit per cycle conversion keeps the divider small
`timescale 1ns/100ps
`include "cpp_defines.svh"

module cpp_reply_tx
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        send,
    input  wire logic [31:0] value,
    input  wire logic        tx_ready,
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    output logic             busy
);

    cpp_pkg::cpp_tstate_type state_q;
    logic [31:0] val_q;
    logic [3:0]  dig_q [`CPP_DIGITS];
    logic [3:0]  cnt_q;
    logic        take;

    assign take = tx_valid && tx_ready;
    assign busy = (state_q != cpp_pkg::T_IDLE);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q  <= cpp_pkg::T_IDLE;
            val_q    <= 32'h0000_0000;
            cnt_q    <= 4'h0;
            tx_data  <= 8'h00;
            tx_valid <= 1'b0;
            for (int i = 0; i < `CPP_DIGITS; i++)
                dig_q[i] <= 4'h0;
        end
        else
        begin
            unique case (state_q)
                cpp_pkg::T_IDLE:
                    if (send)
                    begin
                        val_q   <= value;
                        cnt_q   <= 4'h0;
                        state_q <= cpp_pkg::T_CONV;
                    end
                cpp_pkg::T_CONV:
                begin
                    // Least significant digit first; zero still gives one
                    dig_q[cnt_q] <= 4'(val_q % 32'h0000_000a);
                    val_q        <= val_q / 32'h0000_000a;
                    cnt_q        <= cnt_q + 4'h1;
                    if (val_q < 32'h0000_000a)
                    begin
                        tx_data  <= `CPP_CH_HASH;
                        tx_valid <= 1'b1;
                        state_q  <= cpp_pkg::T_HASH;
                    end
                end
                cpp_pkg::T_HASH:
                    if (take)
                    begin
                        cnt_q    <= cnt_q - 4'h1;
                        tx_data  <= `CPP_CH_ZERO + {4'h0, dig_q[cnt_q - 4'h1]};
                        state_q  <= cpp_pkg::T_DIG;
                    end
                cpp_pkg::T_DIG:
                    if (take)
                    begin
                        if (cnt_q == 4'h0)
                        begin
                            tx_data <= `CPP_CH_CR;
                            state_q <= cpp_pkg::T_TERM;
                        end
                        else
                        begin
                            cnt_q   <= cnt_q - 4'h1;
                            tx_data <= `CPP_CH_ZERO
                                       + {4'h0, dig_q[cnt_q - 4'h1]};
                        end
                    end
                cpp_pkg::T_TERM:
                    if (take)
                    begin
                        tx_valid <= 1'b0;
                        state_q  <= cpp_pkg::T_IDLE;
                    end
            endcase
        end
    end

endmodule

//--- design/cpp_parser.sv
// Purpose: ASCII command interpreter for cyclic profiles and FF gain
// Assumes: Host waits for each reply before sending the next frame
// Notes:   Bytes arriving while a reply is pending are dropped
`timescale 1ns/100ps
`include "cpp_defines.svh"

module cpp_parser
#(
    parameter logic [31:0] CTRL_ID  = 32'h0000_0001,
    parameter logic [31:0] CURR_RES = 32'h0000_5b8e
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    input  wire logic        tx_ready,
    input  wire logic        trigger_in,
    input  wire logic [3:0]  profile_done,
    input  wire logic [63:0] wanted_pos,
    output logic [7:0]       tx_data,
    output logic             tx_valid,
    output logic [3:0]       profile_start_q,
    output logic [63:0]      profile_curve_q,
    output logic [3:0]       use_offset_q,
    output logic [63:0]      curve_pos_offset_q,
    output logic [3:0]       cyclic_active_q,
    output logic [3:0]       trigger_wait_q,
    output logic [63:0]      ff_accel_gain_q,
    output logic             frame_busy_q
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic cpp_pkg::cpp_cmd_type decode_cmd(
        input logic [7:0] c1,
        input logic [7:0] c2
    );
        decode_cmd = cpp_pkg::CMD_NONE;
        if (c1 == `CPP_CH_C && c2 == `CPP_CH_C)
            decode_cmd = cpp_pkg::CMD_START_IMM;
        else if (c1 == `CPP_CH_C && c2 == `CPP_CH_T)
            decode_cmd = cpp_pkg::CMD_TRIG_START;
        else if (c1 == `CPP_CH_C && c2 == `CPP_CH_B)
            decode_cmd = cpp_pkg::CMD_TRIG_POS;
        else if (c1 == `CPP_CH_C && c2 == `CPP_CH_S)
            decode_cmd = cpp_pkg::CMD_CS;
        else if (c1 == `CPP_CH_C && c2 == `CPP_CH_I)
            decode_cmd = cpp_pkg::CMD_RES_QUERY;
        else if (c1 == `CPP_CH_D && c2 == `CPP_CH_A)
            decode_cmd = cpp_pkg::CMD_FF_GAIN;
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        is_digit = (c >= `CPP_CH_ZERO) && (c <= `CPP_CH_NINE);
    endfunction

    function automatic logic is_drive(input logic [7:0] c);
        is_drive = (c >= `CPP_CH_A) && (c <= `CPP_CH_D);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Frame reception

    cpp_pkg::cpp_pstate_type state_q;
    cpp_pkg::cpp_cmd_type    cmd_q;
    logic [7:0]  c1_q;
    logic [31:0] num_q;
    logic        num_seen_q;
    logic        ovf_q;
    logic        drive_seen_q;
    logic        fmt_err_q;
    logic [1:0]  drive_q;
    logic [35:0] acc;
    logic        rx_take;
    logic        tx_busy;
    logic        send_q;
    logic [31:0] reply_q;

    assign rx_take = rx_valid && (state_q != cpp_pkg::P_EXEC)
                     && (state_q != cpp_pkg::P_WAIT);
    assign acc = {4'h0, num_q} * `CPP_DEC_BASE
                 + {28'h000_0000, rx_data - `CPP_CH_ZERO};

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q      <= cpp_pkg::P_IDLE;
            cmd_q        <= cpp_pkg::CMD_NONE;
            c1_q         <= 8'h00;
            num_q        <= 32'h0000_0000;
            num_seen_q   <= 1'b0;
            ovf_q        <= 1'b0;
            drive_seen_q <= 1'b0;
            fmt_err_q    <= 1'b0;
            drive_q      <= 2'h0;
        end
        else
        begin
            unique case (state_q)
                cpp_pkg::P_IDLE:
                    if (rx_take && rx_data == `CPP_CH_START)
                    begin
                        num_q        <= 32'h0000_0000;
                        num_seen_q   <= 1'b0;
                        ovf_q        <= 1'b0;
                        drive_seen_q <= 1'b0;
                        fmt_err_q    <= 1'b0;
                        state_q      <= cpp_pkg::P_CMD1;
                    end
                cpp_pkg::P_CMD1:
                    if (rx_take)
                    begin
                        c1_q    <= rx_data;
                        state_q <= cpp_pkg::P_CMD2;
                    end
                cpp_pkg::P_CMD2:
                    if (rx_take)
                    begin
                        cmd_q   <= decode_cmd(c1_q, rx_data);
                        state_q <= cpp_pkg::P_ARGS;
                    end
                cpp_pkg::P_ARGS:
                    if (rx_take)
                    begin
                        if (rx_data == `CPP_CH_CR)
                            state_q <= cpp_pkg::P_EXEC;
                        else if (is_digit(rx_data) && !drive_seen_q)
                        begin
                            num_seen_q <= 1'b1;
                            if (acc > `CPP_NUM_LIMIT)
                                ovf_q <= 1'b1;
                            num_q <= acc[31:0];
                        end
                        else if (is_drive(rx_data) && !drive_seen_q)
                        begin
                            drive_seen_q <= 1'b1;
                            drive_q      <= 2'(rx_data - `CPP_CH_A);
                        end
                        else
                            fmt_err_q <= 1'b1;
                    end
                cpp_pkg::P_EXEC:
                    state_q <= cpp_pkg::P_WAIT;
                cpp_pkg::P_WAIT:
                    if (!send_q && !tx_busy)
                        state_q <= cpp_pkg::P_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            frame_busy_q <= 1'b0;
        else
            frame_busy_q <= (state_q == cpp_pkg::P_CMD2 && rx_take)
                            || (state_q != cpp_pkg::P_IDLE
                                && state_q != cpp_pkg::P_CMD1
                                && !(state_q == cpp_pkg::P_WAIT
                                     && !send_q && !tx_busy));
    end

    ////////////////////////////////////////////////////////////////////
    // Command checks

    logic args_ok;
    logic drive_args_ok;
    logic exec;
    logic motion_ok;
    logic id_match;

    assign args_ok       = num_seen_q && !ovf_q && !fmt_err_q;
    assign drive_args_ok = args_ok && drive_seen_q;
    assign exec          = (state_q == cpp_pkg::P_EXEC);
    assign motion_ok     = drive_args_ok && (num_q <= `CPP_CURVE_MAX);
    assign id_match      = args_ok && !drive_seen_q
                           && (num_q == CTRL_ID);

    logic [3:0] start_now;
    logic [3:0] arm_trig;
    logic [3:0] stop_sel;

    always_comb
    begin
        start_now = 4'h0;
        arm_trig  = 4'h0;
        stop_sel  = 4'h0;
        if (exec && motion_ok && cmd_q == cpp_pkg::CMD_START_IMM)
            start_now[drive_q] = 1'b1;
        if (exec && motion_ok
            && (cmd_q == cpp_pkg::CMD_TRIG_START
                || cmd_q == cpp_pkg::CMD_TRIG_POS))
            arm_trig[drive_q] = 1'b1;
        // Drive letter only picks this controller, mask picks motors
        if (exec && drive_args_ok && cmd_q == cpp_pkg::CMD_CS
            && num_q <= `CPP_MASK_MAX)
            stop_sel = num_q[3:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Replies

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            send_q  <= 1'b0;
            reply_q <= `CPP_ACK_OK;
        end
        else
        begin
            send_q <= 1'b0;
            if (exec)
            begin
                unique case (cmd_q)
                    cpp_pkg::CMD_RES_QUERY:
                    begin
                        // Other controllers' ids are not ours to answer
                        send_q  <= id_match;
                        reply_q <= CURR_RES;
                    end
                    cpp_pkg::CMD_START_IMM, cpp_pkg::CMD_TRIG_START,
                    cpp_pkg::CMD_TRIG_POS:
                    begin
                        send_q  <= 1'b1;
                        reply_q <= motion_ok ? `CPP_ACK_OK : `CPP_ACK_ERR;
                    end
                    cpp_pkg::CMD_CS:
                    begin
                        send_q  <= 1'b1;
                        reply_q <= (drive_args_ok && num_q <= `CPP_MASK_MAX)
                                   ? `CPP_ACK_OK : `CPP_ACK_ERR;
                    end
                    cpp_pkg::CMD_FF_GAIN:
                    begin
                        send_q  <= 1'b1;
                        reply_q <= (drive_args_ok && num_q <= `CPP_GAIN_MAX)
                                   ? `CPP_ACK_OK : `CPP_ACK_ERR;
                    end
                    cpp_pkg::CMD_NONE:
                    begin
                        send_q  <= 1'b1;
                        reply_q <= `CPP_ACK_ERR;
                    end
                endcase
            end
        end
    end

    cpp_reply_tx u_tx
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .send     (send_q),
        .value    (reply_q),
        .tx_ready (tx_ready),
        .tx_data  (tx_data),
        .tx_valid (tx_valid),
        .busy     (tx_busy)
    );

    ////////////////////////////////////////////////////////////////////
    // Cyclic profile control

    logic trig_prev_q;
    logic trig_rise;
    logic [3:0] launch;

    assign trig_rise = trigger_in && !trig_prev_q;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            trig_prev_q <= 1'b0;
        else
            trig_prev_q <= trigger_in;
    end

    always_comb
    begin
        for (int m = 0; m < `CPP_MOTORS; m++)
            launch[m] = start_now[m]
                        || (trig_rise && trigger_wait_q[m])
                        || (profile_done[m] && cyclic_active_q[m]
                            && !trigger_wait_q[m]);
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cyclic_active_q <= 4'h0;
            trigger_wait_q  <= 4'h0;
            profile_start_q <= 4'h0;
        end
        else
        begin
            profile_start_q <= launch;
            for (int m = 0; m < `CPP_MOTORS; m++)
            begin
                if (start_now[m] || arm_trig[m])
                    cyclic_active_q[m] <= 1'b1;
                else if (stop_sel[m])
                    cyclic_active_q[m] <= 1'b0;
                if (arm_trig[m])
                    trigger_wait_q[m] <= 1'b1;
                else if ((trig_rise && trigger_wait_q[m]) || stop_sel[m])
                    trigger_wait_q[m] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            profile_curve_q    <= 64'h0;
            use_offset_q       <= 4'h0;
            curve_pos_offset_q <= 64'h0;
        end
        else
        begin
            for (int m = 0; m < `CPP_MOTORS; m++)
            begin
                if (start_now[m] || arm_trig[m])
                begin
                    profile_curve_q[m*16 +: 16] <= num_q[15:0];
                    use_offset_q[m] <= (cmd_q == cpp_pkg::CMD_TRIG_POS);
                end
                // Each run of the position variant re-bases its offset
                if (launch[m] && use_offset_q[m] && !start_now[m])
                    curve_pos_offset_q[m*16 +: 16]
                        <= wanted_pos[m*16 +: 16];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ff_accel_gain_q <= 64'h0;
        else if (exec && cmd_q == cpp_pkg::CMD_FF_GAIN && drive_args_ok
                 && num_q <= `CPP_GAIN_MAX)
            ff_accel_gain_q[drive_q*16 +: 16] <= num_q[15:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    a_trig_launch: assert property (
        @(posedge clock) disable iff (!rst_n)
        trig_rise && trigger_wait_q[3] |=> profile_start_q[3])
        else $error("armed motor D missed trigger launch");
    a_no_early: assert property (
        @(posedge clock) disable iff (!rst_n)
        trigger_wait_q[2] && !trig_rise |=> !profile_start_q[2])
        else $error("motor C launched before trigger");
    a_cyclic_restart: assert property (
        @(posedge clock) disable iff (!rst_n)
        profile_done[2] && cyclic_active_q[2] && !trigger_wait_q[2]
        |=> profile_start_q[2])
        else $error("motor C cyclic profile not restarted");
    a_repeat_notrig: assert property (
        @(posedge clock) disable iff (!rst_n)
        trig_rise && trigger_wait_q[2] && !arm_trig[2] && !stop_sel[2]
        |=> !trigger_wait_q[2] && cyclic_active_q[2])
        else $error("motor C still waits after first trigger");
    a_stop_final: assert property (
        @(posedge clock) disable iff (!rst_n)
        !cyclic_active_q[0] && !start_now[0] && !trigger_wait_q[0]
        && profile_done[0] |=> !profile_start_q[0])
        else $error("stopped motor A restarted");
    a_stop_mask: assert property (
        @(posedge clock) disable iff (!rst_n)
        stop_sel[0] && !start_now[0] && !arm_trig[0]
        |=> !cyclic_active_q[0] && !trigger_wait_q[0])
        else $error("mask bit 0 did not stop motor A");
    a_offset_load: assert property (
        @(posedge clock) disable iff (!rst_n)
        launch[3] && use_offset_q[3] && !start_now[3]
        |=> curve_pos_offset_q[63:48] == $past(wanted_pos[63:48]))
        else $error("curve position offset not updated");
    a_imm_reply: assert property (
        @(posedge clock) disable iff (!rst_n)
        exec && cmd_q == cpp_pkg::CMD_START_IMM
        |=> send_q ##2 tx_valid && tx_data == `CPP_CH_HASH)
        else $error("immediate command reply missing");
    a_res_value: assert property (
        @(posedge clock) disable iff (!rst_n)
        exec && cmd_q == cpp_pkg::CMD_RES_QUERY && id_match
        |=> send_q && reply_q == CURR_RES)
        else $error("resolution reply wrong");
    a_gain_range: assert property (
        @(posedge clock) disable iff (!rst_n)
        exec && cmd_q == cpp_pkg::CMD_FF_GAIN && num_q > `CPP_GAIN_MAX
        |=> $stable(ff_accel_gain_q))
        else $error("out of range gain stored");

endmodule

//--- testbench/cpp_host_model.sv
// Purpose: Host side model that sends command frames and collects replies
// Assumes: One frame at a time; the reply is awaited before the next frame
// Notes:   Idle rx_data shows the inverse of the last byte sent
`timescale 1ns/100ps

module cpp_host_model
(
    input  wire logic       clock,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_valid,
    output logic            tx_ready
);
    logic  slow = 1'b0;
    string rsp = "";

    initial
    begin
        rx_data  = 8'h00;
        rx_valid = 1'b0;
    end

    // Slow mode stalls every other cycle to stretch each reply byte
    always @(negedge clock)
        tx_ready <= slow ? ~tx_ready : 1'b1;

    always @(posedge clock)
        if (tx_valid && tx_ready)
            rsp = {rsp, string'(tx_data)};

    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input string s, output string r);
        int n;
        rsp = "";
        for (int i = 0; i < s.len(); i++)
        begin
            @(negedge clock);
            rx_data  = s[i];
            rx_valid = 1'b1;
            @(negedge clock);
            rx_valid = 1'b0;
            rx_data  = ~rx_data;
        end
        n = 0;
        while (n < 300 && (rsp.len() == 0 || rsp[rsp.len()-1] != 8'h0d))
        begin
            @(negedge clock);
            n++;
        end
        // Dropped-byte window after the final reply byte
        repeat (2) @(negedge clock);
        r = rsp;
    endtask
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench of the command parser
// Assumes: Host model drives the byte link; bench drives motor inputs
// Notes:   Motors A, C and D get one motion command each, B none; mask 1 stops motor A before C and D start
`timescale 1ns/100ps

module tb_top;
    typedef struct { string cmd; string rsp; } cpp_row_type;
    logic        clock, rst_n, rx_valid, tx_ready, tx_valid, trigger_in;
    logic        frame_busy_q;
    logic [7:0]  rx_data, tx_data;
    logic [3:0]  profile_done, profile_start_q, use_offset_q;
    logic [3:0]  cyclic_active_q, trigger_wait_q;
    logic [63:0] wanted_pos, profile_curve_q, curve_pos_offset_q;
    logic [63:0] ff_accel_gain_q;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n;
    int          busy_n = 0;
    string       r;
    cpp_row_type rows [4];

    cpp_parser u_dut (.clock(clock), .rst_n(rst_n), .rx_data(rx_data),
        .rx_valid(rx_valid), .tx_ready(tx_ready), .trigger_in(trigger_in),
        .profile_done(profile_done), .wanted_pos(wanted_pos),
        .tx_data(tx_data), .tx_valid(tx_valid),
        .profile_start_q(profile_start_q), .profile_curve_q(profile_curve_q),
        .use_offset_q(use_offset_q), .curve_pos_offset_q(curve_pos_offset_q),
        .cyclic_active_q(cyclic_active_q), .trigger_wait_q(trigger_wait_q),
        .ff_accel_gain_q(ff_accel_gain_q), .frame_busy_q(frame_busy_q));

    cpp_host_model u_host (.clock(clock), .tx_data(tx_data),
        .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_ready(tx_ready));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(negedge clock)
        if (frame_busy_q === 1'b1)
            busy_n++;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        n_compared++;
        if (g !== e)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmd(input string c, input string e);
        u_host.xfer(c, r);
        n_compared++;
        if (r != e)
        begin
            fail_count++;
            $display("Error reply to %s expected %s seen %s", c, e, r);
        end
    endtask

    // Counts start pulses of motor m in the four cycles after the cause
    task automatic kick(input logic [3:0] d, input logic t, input int m,
                        output int k);
        @(negedge clock);
        profile_done = d;
        trigger_in   = t;
        k = 0;
        repeat (4)
        begin
            @(negedge clock);
            profile_done = 4'h0;
            if (profile_start_q[m] === 1'b1)
                k++;
        end
    endtask

    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #100000;
        fail_count++;
        stop_test;
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst_n        = 1'b0;
        trigger_in   = 1'b0;
        profile_done = 4'h0;
        wanted_pos   = 64'h1234_0000_0000_0000;
        rows[0] = '{"!CI1\015", "#23438\015"};
        rows[1] = '{"!DA32640B\015", "#0\015"};
        rows[2] = '{"!DA32641B\015", "#1\015"};
        rows[3] = '{"!CC7A\015", "#0\015"};
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        chk("cyclic after reset", 64'h0, cyclic_active_q);
        chk("tx_valid after reset", 64'h0, tx_valid);
        foreach (rows[i])
        begin
            u_host.slow = i[0];
            cmd(rows[i].cmd, rows[i].rsp);
        end
        u_host.slow = 1'b0;
        chk("ff gain B", 64'h7f80, ff_accel_gain_q[31:16]);
        chk("curve A", 64'h7, profile_curve_q[15:0]);
        chk("active A", 64'h1, cyclic_active_q[0]);
        kick(4'h1, 1'b0, 0, n);
        chk("restart A", 64'h1, n);
        cmd("!CS2A\015", "#0\015");
        chk("active A after B stop", 64'h1, cyclic_active_q[0]);
        cmd("!CS1D\015", "#0\015");
        chk("active A after stop", 64'h0, cyclic_active_q[0]);
        kick(4'h1, 1'b0, 0, n);
        chk("no restart A", 64'h0, n);
        cmd("!CT5C\015", "#0\015");
        chk("armed C", 64'h1, trigger_wait_q[2]);
        kick(4'h4, 1'b0, 2, n);
        chk("start C without trigger", 64'h0, n);
        kick(4'h0, 1'b1, 2, n);
        chk("trigger start C", 64'h1, n);
        kick(4'h4, 1'b0, 2, n);
        chk("restart C no trigger", 64'h1, n);
        cmd("!CB9D\015", "#0\015");
        chk("offset D armed", 64'h0, curve_pos_offset_q[63:48]);
        kick(4'h0, 1'b1, 3, n);
        chk("trigger start D", 64'h1, n);
        chk("offset D", 64'h1234, curve_pos_offset_q[63:48]);
        chk("offset mode D", 64'h1, use_offset_q[3]);
        cmd("!CI2\015", "");
        chk("frame idle", 64'h0, frame_busy_q);
        chk("frame busy seen", 64'h1, busy_n > 0);
        rst_n = 1'b0;
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        chk("wait after reset", 64'h0, trigger_wait_q);
        chk("active after reset", 64'h0, cyclic_active_q);
        chk("gain after reset", 64'h0, ff_accel_gain_q);
        cmd("!CI1\015", "#23438\015");
        stop_test;
    end
endmodule
